// [rtl/rps_pkg.sv]
// Purpose: Shared constants and types for the rail power sequencer configuration block.
// Assumes: 100 MHz system clock, register access through an 8-bit subaddress port.
// Notes: Counts of cycles are derived from the times in milliseconds.
package rps_pkg;

    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned WAIT_SHORT_MS = 2;
    localparam int unsigned WAIT_LONG_MS = 5;
    localparam int unsigned WAIT_SHORT_CYC = WAIT_SHORT_MS * (CLK_HZ / 1000);
    localparam int unsigned WAIT_LONG_CYC = WAIT_LONG_MS * (CLK_HZ / 1000);
    localparam int unsigned DOWN_FACTOR = 10;
    localparam int unsigned CNT_W = 24;

    localparam logic [7:0] ADDR_DELAY_LO = 8'h20;
    localparam logic [7:0] ADDR_DELAY_HI = 8'h21;
    localparam logic [7:0] ADDR_SLOT_ASSIGN = 8'h22;
    localparam logic [7:0] ADDR_UNLOCK = 8'h10;
    localparam logic [7:0] UNLOCK_KEY = 8'h7d;

    localparam logic [7:0] RST_DELAY_LO = 8'h00;
    localparam logic [7:0] RST_DELAY_HI = 8'h00;
    localparam logic [7:0] RST_SLOT_ASSIGN = 8'h98;

    localparam int unsigned MULT_BIT = 7;
    localparam int unsigned WAIT9_BIT = 0;
    localparam logic [7:0] DELAY_HI_WMASK = 8'h81;
    localparam int unsigned FIELD_LSB = 4;
    localparam logic [3:0] SLOT_FIRST = 4'h1;
    localparam logic [3:0] SLOT_LAST = 4'ha;
    localparam logic [3:0] SLOT_MIN_ASSIGN = 4'h3;

    typedef enum {RPS_IDLE, RPS_STROBE, RPS_WAIT} rps_fsm_t;

    typedef struct packed {
        logic load;
        logic [CNT_W-1:0] count;
    } rps_tmr_req_t;

    typedef struct packed {
        logic [7:0] delay_lo;
        logic [7:0] delay_hi;
        logic [7:0] slot_assign;
    } rps_regs_t;

    typedef struct packed {
        rps_fsm_t fsm;
        rps_regs_t regs;
        logic unlocked;
        logic down;
        logic [3:0] slot;
        logic strobe;
        logic rail_en;
        logic busy;
        logic [7:0] rd_data;
        rps_tmr_req_t tmr;
    } rps_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic done;
    } rps_tmr_state_t;

endpackage : rps_pkg

// [rtl/rps_wait_timer.sv]
// Purpose: Down counter that marks the end of one inter-slot wait.
// Assumes: Load and count come from logic on the same clock.
// Notes: Done pulses for one cycle exactly count+1 cycles after the load cycle.
`timescale 1ns/1ps
`default_nettype none
module rps_wait_timer
    import rps_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire rps_tmr_req_t i_req,
    output logic o_done
);

    rps_tmr_state_t st_q;
    rps_tmr_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (i_req.load) begin
            st_d.cnt = i_req.count;
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
            st_d.done = (st_q.cnt == CNT_W'(1));
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_done = st_q.done;

endmodule : rps_wait_timer
`default_nettype wire

// [rtl/rps_seq_cfg.sv]
// Purpose: Sequencer configuration registers and the slot stepping they steer.
// Assumes: The serial front end delivers decoded subaddress writes and reads.
// Notes: Start requests come from the power-state logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Low delay register bit k picks wait between slot k+1 and slot k+2: 0 short, 1 long.
// - High delay register bit 0 picks wait between slot 9 and slot 10.
// - Multiplier bit 7 set stretches every wait tenfold during power-down.
// - Power-up always uses the unscaled per-slot waits.
// - Field value 3h to Ah enables the second buck rail at that slot.
// - Other field values leave the rail outside sequencer control, never enabled.
// - Slot assignment resets to 98h; both delay registers reset to 00h.
module rps_seq_cfg
    import rps_pkg::*;
#(
    parameter int unsigned P_SHORT_CYC = WAIT_SHORT_CYC,
    parameter int unsigned P_LONG_CYC = WAIT_LONG_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_wr,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_start_up,
    input wire logic i_start_down,
    output logic [7:0] o_rd_data,
    output logic o_unlocked,
    output logic [3:0] o_slot,
    output logic o_strobe,
    output logic o_rail_en,
    output logic o_busy
);

    rps_state_t st_q;
    rps_state_t st_d;
    logic tmr_done;
    logic [9:0] wait_bits;
    logic [3:0] field;
    logic field_valid;
    logic [3:0] wait_idx;
    logic [CNT_W-1:0] base_cnt;
    logic [CNT_W-1:0] load_cnt;
    logic cfg_addr;

    rps_wait_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_req(st_q.tmr),
        .o_done(tmr_done)
    );

    assign wait_bits = {st_q.regs.delay_hi[WAIT9_BIT], st_q.regs.delay_lo};
    assign field = st_q.regs.slot_assign[FIELD_LSB+3:FIELD_LSB];
    assign field_valid = (field >= SLOT_MIN_ASSIGN) && (field <= SLOT_LAST);
    assign wait_idx = st_q.down ? (st_q.slot - 4'h2) : (st_q.slot - 4'h1);
    assign base_cnt = wait_bits[wait_idx] ? CNT_W'(P_LONG_CYC) : CNT_W'(P_SHORT_CYC);
    // Scaling applies only while stepping down.
    assign load_cnt = (st_q.down && st_q.regs.delay_hi[MULT_BIT]) ?
                      CNT_W'(base_cnt * DOWN_FACTOR) : base_cnt;
    assign cfg_addr = (i_addr == ADDR_DELAY_LO) || (i_addr == ADDR_DELAY_HI) ||
                      (i_addr == ADDR_SLOT_ASSIGN);

    always_comb begin
        st_d = st_q;
        st_d.strobe = 1'b0;
        st_d.tmr.load = 1'b0;

        // The unlock arms exactly one configuration write; any other write disarms it.
        if (i_wr) begin
            st_d.unlocked = (i_addr == ADDR_UNLOCK) && (i_wdata == UNLOCK_KEY);
            if (cfg_addr && st_q.unlocked) begin
                case (i_addr)
                    ADDR_DELAY_LO: st_d.regs.delay_lo = i_wdata;
                    ADDR_DELAY_HI: st_d.regs.delay_hi = i_wdata & DELAY_HI_WMASK;
                    default: st_d.regs.slot_assign = i_wdata;
                endcase
            end
        end

        case (i_addr)
            ADDR_DELAY_LO: st_d.rd_data = st_q.regs.delay_lo;
            ADDR_DELAY_HI: st_d.rd_data = st_q.regs.delay_hi;
            ADDR_SLOT_ASSIGN: st_d.rd_data = st_q.regs.slot_assign;
            default: st_d.rd_data = 8'h00;
        endcase

        case (st_q.fsm)
            RPS_IDLE: begin
                if (i_start_up || i_start_down) begin
                    st_d.down = !i_start_up;
                    st_d.slot = i_start_up ? SLOT_FIRST : SLOT_LAST;
                    st_d.strobe = 1'b1;
                    st_d.busy = 1'b1;
                    st_d.fsm = RPS_STROBE;
                end
            end
            RPS_STROBE: begin
                if (field_valid && (st_q.slot == field)) begin
                    st_d.rail_en = !st_q.down;
                end
                if ((!st_q.down && st_q.slot == SLOT_LAST) ||
                    (st_q.down && st_q.slot == SLOT_FIRST)) begin
                    st_d.busy = 1'b0;
                    st_d.fsm = RPS_IDLE;
                end else begin
                    st_d.tmr.load = 1'b1;
                    st_d.tmr.count = load_cnt;
                    st_d.fsm = RPS_WAIT;
                end
            end
            RPS_WAIT: begin
                if (tmr_done) begin
                    st_d.slot = st_q.down ? (st_q.slot - 4'h1) : (st_q.slot + 4'h1);
                    st_d.strobe = 1'b1;
                    st_d.fsm = RPS_STROBE;
                end
            end
            default: st_d.fsm = RPS_IDLE;
        endcase

        // A rail outside sequencer control is held off.
        if (!field_valid) begin
            st_d.rail_en = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
            st_q.fsm <= RPS_IDLE;
            st_q.regs.delay_lo <= RST_DELAY_LO;
            st_q.regs.delay_hi <= RST_DELAY_HI;
            st_q.regs.slot_assign <= RST_SLOT_ASSIGN;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rd_data = st_q.rd_data;
    assign o_unlocked = st_q.unlocked;
    assign o_slot = st_q.slot;
    assign o_strobe = st_q.strobe;
    assign o_rail_en = st_q.rail_en;
    assign o_busy = st_q.busy;

    // Checks on the register port, the slot stepping and the rail enable.
    rst_vals_a: assert property (@(posedge i_clk_sys) $rose(i_nrst) |->
        st_q.regs.delay_lo == 8'h00 && st_q.regs.delay_hi == 8'h00 &&
        st_q.regs.slot_assign == 8'h98)
        else $error("Register reset values wrong.");

    lock_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_wr && cfg_addr && !st_q.unlocked |=> $stable(st_q.regs))
        else $error("Locked write changed a register.");

    // An armed slot assignment write must land whatever idle cycles came before it.
    unlock_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_wr && i_addr == ADDR_SLOT_ASSIGN && st_q.unlocked |=>
        st_q.regs.slot_assign == $past(i_wdata))
        else $error("Unlocked write did not land.");

    rsvd_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.regs.delay_hi[6:1] == 6'h00)
        else $error("Reserved delay bits became set.");

    slot_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !field_valid |=> !o_rail_en)
        else $error("Uncontrolled rail was enabled.");

    slot_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.fsm == RPS_STROBE && !st_q.down && field_valid && st_q.slot == field
        ##1 field_valid |-> o_rail_en)
        else $error("Rail not enabled at its slot.");

    // The wait is chosen in the strobe cycle, so compare against the values seen then.
    up_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.tmr.load && !st_q.down |-> st_q.tmr.count ==
        ($past(wait_bits[st_q.slot - 4'h1]) ? CNT_W'(P_LONG_CYC) : CNT_W'(P_SHORT_CYC)))
        else $error("Power-up wait does not match its select bit.");

    down_wait_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.tmr.load && st_q.down |-> st_q.tmr.count ==
        CNT_W'(($past(wait_bits[st_q.slot - 4'h2]) ? P_LONG_CYC : P_SHORT_CYC) *
        ($past(st_q.regs.delay_hi[MULT_BIT]) ? DOWN_FACTOR : 32'h1)))
        else $error("Power-down wait does not match its select and factor bits.");

    down_scale_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.tmr.load && st_q.down && $past(st_q.regs.delay_hi[MULT_BIT]) |->
        st_q.tmr.count >= CNT_W'(P_SHORT_CYC * DOWN_FACTOR))
        else $error("Power-down wait not stretched.");

    up_unscaled_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.tmr.load && !st_q.down |-> st_q.tmr.count <= CNT_W'(P_LONG_CYC))
        else $error("Power-up wait was scaled.");

    // A start that arrives mid-sequence must not disturb the slot being stepped.
    busy_refuse_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.fsm != RPS_IDLE && !tmr_done && (i_start_up || i_start_down) |=>
        $stable(st_q.slot) && $stable(st_q.down))
        else $error("Start taken while busy.");

    strobe_range_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_strobe |-> (o_slot >= SLOT_FIRST) && (o_slot <= SLOT_LAST))
        else $error("Strobe outside slot range.");

    armed_once_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_wr && !(i_addr == ADDR_UNLOCK && i_wdata == UNLOCK_KEY) |=> !o_unlocked)
        else $error("Unlock stayed armed after a write.");

    // Main scenarios: full power-up, stretched power-down, refused write, both starts, rail on.
    up_done_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_strobe && !st_q.down && o_slot == SLOT_LAST);
    down_scaled_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.tmr.load && st_q.down && st_q.regs.delay_hi[MULT_BIT]);
    locked_wr_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_wr && cfg_addr && !st_q.unlocked);
    both_start_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
        st_q.fsm == RPS_IDLE && i_start_up && i_start_down);
    rail_on_c: cover property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $rose(o_rail_en));

endmodule : rps_seq_cfg
`default_nettype wire

// [verification/rps_host_model.sv]
// Purpose: Host model that drives the configuration register port.
// Assumes: Single byte transfers with one write strobe each.
// Notes: Idle write data shows the inverse of the last byte sent.
`timescale 1ns/1ps
`default_nettype none
module rps_host_model
    import rps_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rd_data,
    output logic o_wr,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : put
    // The key write arms exactly one following write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit unlock);
        if (unlock) put(ADDR_UNLOCK, UNLOCK_KEY);
        put(a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        o_addr <= a;
        repeat (2) @(posedge i_clk_sys);
        #1 d = i_rd_data;
    endtask : rd
endmodule : rps_host_model
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the sequencer configuration block.
// Assumes: Waits shortened to 4 and 10 cycles through the parameters.
// Notes: Each configuration runs one power-up and one power-down.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
    import rps_pkg::*;
    localparam int unsigned SHORT = 4;
    localparam int unsigned LONG = 10;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start_up = 1'b0;
    logic start_dn = 1'b0;
    logic wr, unl, strobe, rail, busy;
    logic [7:0] addr, wdata, rd_data, d, lo, hi;
    logic [3:0] slot, fld;
    logic [3:0] flds [6] = '{4'h9, 4'h3, 4'ha, 4'h0, 4'h2, 4'hb};
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    rps_seq_cfg #(.P_SHORT_CYC(SHORT), .P_LONG_CYC(LONG)) dut (.i_clk_sys(clk), .i_nrst(nrst),
        .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .i_start_up(start_up),
        .i_start_down(start_dn), .o_rd_data(rd_data), .o_unlocked(unl), .o_slot(slot),
        .o_strobe(strobe), .o_rail_en(rail), .o_busy(busy));
    rps_host_model host (.i_clk_sys(clk), .i_rd_data(rd_data), .o_wr(wr), .o_addr(addr),
        .o_wdata(wdata));
    always #5 clk = ~clk;
    task automatic test_done();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            test_done();
        end
    end
    // Spacing from the strobe of slot k to the strobe of its neighbour.
    // The timer handshake adds three cycles on top of the wait itself.
    function automatic int exp_gap(logic [7:0] l, logic [7:0] h, int k, bit up);
        int w;
        w = ((k == 9) ? h[0] : l[k-1]) ? LONG : SHORT;
        if (!up && h[7]) w = w * DOWN_FACTOR;
        return w + 3;
    endfunction : exp_gap
    task automatic run(input bit up, input logic [7:0] l, input logic [7:0] h, input logic [3:0] f);
        int gap;
        logic [3:0] s;
        bit ok;
        ok = (f >= 4'h3) && (f <= 4'ha);
        @(posedge clk);
        // In the power-up run with field 9 both starts come together and power-up must win.
        start_up <= up;
        start_dn <= !up || (f == 4'h9);
        @(posedge clk);
        start_up <= 1'b0;
        start_dn <= 1'b0;
        #1 gap = 0;
        for (int n = 0; n < 10; n++) begin
            while (strobe !== 1'b1 && gap < 2000) begin
                @(posedge clk);
                start_up <= 1'b0;
                start_dn <= 1'b0;
                #1 gap++;
            end
            s = up ? 4'(n + 1) : 4'(10 - n);
            `CHK(slot, s)
            if (n > 0) `CHK(gap, exp_gap(l, h, up ? s - 1 : s, up))
            @(posedge clk);
            // A start in mid-sequence must be ignored.
            start_up <= (n == 4);
            start_dn <= (n == 4);
            #1 gap = 1;
            `CHK(rail, 1'(ok && (up ? s >= f : s > f)))
        end
        `CHK(busy, 1'b0)
    endtask : run
    initial begin
        void'($urandom(96));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        host.rd(ADDR_DELAY_LO, d);
        `CHK(d, 8'h00)
        host.rd(ADDR_DELAY_HI, d);
        `CHK(d, 8'h00)
        host.rd(ADDR_SLOT_ASSIGN, d);
        `CHK(d, 8'h98)
        host.rd(8'h3c, d);
        `CHK(d, 8'h00)
        host.wr(ADDR_SLOT_ASSIGN, 8'h35, 1'b0);
        host.rd(ADDR_SLOT_ASSIGN, d);
        `CHK(d, 8'h98)
        host.put(ADDR_UNLOCK, UNLOCK_KEY);
        #1 `CHK(unl, 1'b1)
        host.wr(8'h3c, 8'h11, 1'b1);
        #1 `CHK(unl, 1'b0)
        host.wr(ADDR_DELAY_LO, 8'hff, 1'b0);
        host.rd(ADDR_DELAY_LO, d);
        `CHK(d, 8'h00)
        $display("test reset and lock done");
        for (int t = 0; t < 6; t++) begin
            lo = 8'($urandom);
            hi = (t == 1) ? 8'hff : 8'($urandom);
            fld = flds[t];
            host.wr(ADDR_DELAY_LO, lo, 1'b1);
            host.wr(ADDR_DELAY_HI, hi, 1'b1);
            host.wr(ADDR_SLOT_ASSIGN, {fld, 4'h8}, 1'b1);
            host.rd(ADDR_DELAY_LO, d);
            `CHK(d, lo)
            host.rd(ADDR_DELAY_HI, d);
            `CHK(d, hi & 8'h81)
            host.rd(ADDR_SLOT_ASSIGN, d);
            `CHK(d, {fld, 4'h8})
            run(1'b1, lo, hi & 8'h81, fld);
            run(1'b0, lo, hi & 8'h81, fld);
            $display("test config %0d done", t);
        end
        // A second reset after the last run must bring back the reset values.
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1 `CHK(slot, 4'h0)
        host.rd(ADDR_DELAY_LO, d);
        `CHK(d, 8'h00)
        host.rd(ADDR_SLOT_ASSIGN, d);
        `CHK(d, 8'h98)
        $display("test second reset done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
